// file: rtl/pmic_seq_cfg.svh
// constants for the power state and sequencing controller
`ifndef PMIC_SEQ_CFG_SVH
`define PMIC_SEQ_CFG_SVH
`define OFF_GLOBAL_EN      8'h00
`define OFF_SLEEP_REQ      8'h01
`define OFF_PDN_MODE       8'h08
`define OFF_THERM_MASK     8'h0a
`define BIT_SLEEP_EN       0
`define BIT_SLEEP_REQ      1
`define BIT_SLEEP_VIA_BUS  1
`define BIT_THERM_UNMASK   4
`define RST_GLOBAL_EN      8'h00
`define RST_SLEEP_REQ      8'h00
`define RST_PDN_MODE       8'h00
`define RST_THERM_MASK     8'h10
`define CLK_HZ             50000000
`define RETRY_MS           100
`define RETRY_CYCLES       ((`CLK_HZ / 1000) * `RETRY_MS)
`endif

// file: rtl/pmic_seq_pkg.sv
// types for the power state and sequencing controller
`default_nettype none
package pmic_seq_pkg;
    typedef enum logic [4:0] {
        ST_COLD    = 5'b00001,
        ST_ACTIVE  = 5'b00010,
        ST_SLEEP   = 5'b00100,
        ST_THERMAL = 5'b01000,
        ST_VFAULT  = 5'b10000
    } pmic_state_t;
    typedef enum logic [1:0] {
        SLP_PRIMARY   = 2'h0,
        SLP_ALTERNATE = 2'h1,
        SLP_OFF       = 2'h2
    } sleep_mode_t;
endpackage : pmic_seq_pkg
`default_nettype wire

// file: rtl/output_sequencer.sv
// per-output trigger, turn-on delay and soft-start sequencer
`default_nettype none
module output_sequencer
    import pmic_seq_pkg::*;
#(
    parameter int DLY_W = 16,
    parameter int SS_W  = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_sync_b,
    input  wire logic             seq_start,
    input  wire logic             direct_on,
    input  wire logic             kill,
    input  wire logic             trigger,
    input  wire logic [DLY_W-1:0] turn_on_delay_field,
    input  wire logic [SS_W-1:0]  soft_start_field,
    output logic                  out_enable,
    output logic                  ramp_done
);
    // ************************************************************
    // delay then ramp counters
    // ************************************************************
    logic             armed_reg;
    logic             armed_next;
    logic [DLY_W-1:0] dly_cnt_reg;
    logic [DLY_W-1:0] dly_cnt_next;
    logic [SS_W-1:0]  ss_cnt_reg;
    logic [SS_W-1:0]  ss_cnt_next;
    logic             en_reg;
    logic             en_next;
    logic             done_reg;
    logic             done_next;

    wire dly_over = (dly_cnt_reg >= turn_on_delay_field);
    wire ss_over  = (ss_cnt_reg >= soft_start_field);
    wire go_on    = armed_reg && trigger && dly_over;

    assign armed_next   = kill ? 1'b0 : (seq_start ? 1'b1
                        : (go_on ? 1'b0 : armed_reg));
    assign dly_cnt_next = (kill || seq_start || !trigger) ? '0
                        : (armed_reg && !dly_over)
                          ? dly_cnt_reg + 1'b1 : dly_cnt_reg;
    assign en_next      = kill ? 1'b0 : (en_reg || go_on || direct_on);
    assign ss_cnt_next  = (!en_reg || kill) ? '0
                        : (ss_over ? ss_cnt_reg : ss_cnt_reg + 1'b1);
    assign done_next    = en_reg && !kill && ss_over;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            armed_reg   <= 1'b0;
            dly_cnt_reg <= '0;
            en_reg      <= 1'b0;
            ss_cnt_reg  <= '0;
            done_reg    <= 1'b0;
        end else begin
            armed_reg   <= armed_next;
            dly_cnt_reg <= dly_cnt_next;
            en_reg      <= en_next;
            ss_cnt_reg  <= ss_cnt_next;
            done_reg    <= done_next;
        end
    end

    assign out_enable = en_reg;
    assign ramp_done  = done_reg;
endmodule : output_sequencer
`default_nettype wire

// file: rtl/pmic_state_ctrl.sv
// master state machine, register port and output sequencing
`include "pmic_seq_cfg.svh"
`default_nettype none
module pmic_state_ctrl
    import pmic_seq_pkg::*;
#(
    parameter int N_BUCK = 4,
    parameter int N_OUT  = 7,
    parameter int DLY_W  = 16,
    parameter int SS_W   = 16,
    parameter int VSET_W = 6,
    parameter int RETRY_CYCLES = `RETRY_CYCLES,
    // factory trigger map: 0..N_OUT-1 = that output's ramp done,
    // N_OUT = supply ok, N_OUT+1 = external good input
    parameter logic [N_OUT*4-1:0] TRIG_SEL = '0,
    parameter logic [N_OUT*DLY_W-1:0] DLY_DEFAULT = '0,
    parameter logic [N_OUT*SS_W-1:0]  SS_DEFAULT  = '0
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic                     supply_in_window,
    input  wire logic                     supply_below_lockout,
    input  wire logic                     over_temp,
    input  wire logic [N_OUT-1:0]         out_over_voltage,
    input  wire logic [N_OUT-1:0]         out_under_voltage,
    input  wire logic                     overvoltage_unmask,
    input  wire logic                     undervoltage_unmask,
    input  wire logic                     power_enable_pin,
    input  wire logic                     external_good_input,
    input  wire logic                     dvs_select,
    input  wire logic [N_OUT*2-1:0]       sleep_mode,
    input  wire logic [N_OUT*DLY_W-1:0]   dly_wdata,
    input  wire logic [N_OUT-1:0]         dly_we,
    input  wire logic [N_OUT*SS_W-1:0]    ss_wdata,
    input  wire logic [N_OUT-1:0]         ss_we,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    output logic [7:0]                    reg_rdata,
    output logic                          bus_reset,
    output logic [N_OUT-1:0]              out_enable,
    output logic [N_BUCK-1:0]             buck_use_alternate,
    output logic                          thermal_shutdown_flag,
    output pmic_state_t                   state,
    output logic                          main_reset_out_b,
    output logic                          aux_reset_out_one_b,
    output logic                          aux_reset_out_two_b
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_s1_reg;
    logic rst_sync_b;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_b <= rst_s1_reg;
        end
    end

    default clocking cb_chk @(posedge mclk);
    endclocking
    default disable iff (!rst_sync_b);

    // ************************************************************
    // state machine
    // ************************************************************
    pmic_state_t state_reg;
    pmic_state_t state_next;
    logic [31:0] retry_cnt_reg;
    logic [31:0] retry_cnt_next;
    logic        pen_reg;
    logic [7:0]  gen_reg;
    logic [7:0]  slp_reg;
    logic [7:0]  pdm_reg;
    logic [7:0]  tmk_reg;
    logic [N_OUT-1:0] ramp_done;
    logic [N_OUT-1:0] seq_en;

    wire is_cold   = (state_reg == ST_COLD);
    wire is_active = (state_reg == ST_ACTIVE);
    wire is_sleep  = (state_reg == ST_SLEEP);
    wire therm_trip = over_temp && tmk_reg[`BIT_THERM_UNMASK];
    wire ov_trip   = overvoltage_unmask && (|(out_over_voltage & out_enable));
    wire uv_trip   = undervoltage_unmask
                   && (|(out_under_voltage & ramp_done));
    wire bus_sleep_ok = pdm_reg[`BIT_SLEEP_VIA_BUS]
                      && gen_reg[`BIT_SLEEP_EN];
    wire bus_access = reg_wr && !bus_reset;
    wire sleep_write = bus_access && (reg_addr == `OFF_SLEEP_REQ)
                     && reg_wdata[`BIT_SLEEP_REQ] && bus_sleep_ok;
    wire pen_toggle = (power_enable_pin != pen_reg);
    wire retry_done = (retry_cnt_reg >= 32'(RETRY_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        if (supply_below_lockout) begin
            state_next = ST_COLD;
        end else begin
            unique case (state_reg)
                ST_COLD: begin
                    if (supply_in_window) begin
                        state_next = ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (therm_trip) begin
                        state_next = ST_THERMAL;
                    end else if (ov_trip || uv_trip) begin
                        state_next = ST_VFAULT;
                    end else if (sleep_write) begin
                        state_next = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (therm_trip) begin
                        state_next = ST_THERMAL;
                    end else if (ov_trip || uv_trip) begin
                        state_next = ST_VFAULT;
                    end else if (pen_toggle) begin
                        state_next = ST_ACTIVE;
                    end
                end
                ST_THERMAL: begin
                    if (!over_temp || !tmk_reg[`BIT_THERM_UNMASK]) begin
                        state_next = ST_COLD;
                    end
                end
                ST_VFAULT: begin
                    if (retry_done) begin
                        state_next = ST_ACTIVE;
                    end
                end
                default: state_next = ST_COLD;
            endcase
        end
    end

    assign retry_cnt_next = (state_reg == ST_VFAULT)
                          ? retry_cnt_reg + 32'h1 : 32'h0;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_reg     <= ST_COLD;
            retry_cnt_reg <= 32'h0;
            pen_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            retry_cnt_reg <= retry_cnt_next;
            pen_reg       <= power_enable_pin;
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    assign bus_reset = !(is_active || is_sleep) || is_sleep;
    wire wr_gen = bus_access && (reg_addr == `OFF_GLOBAL_EN);
    wire wr_slp = bus_access && (reg_addr == `OFF_SLEEP_REQ);
    wire wr_pdm = bus_access && (reg_addr == `OFF_PDN_MODE);
    wire wr_tmk = bus_access && (reg_addr == `OFF_THERM_MASK);

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            gen_reg <= `RST_GLOBAL_EN;
            slp_reg <= `RST_SLEEP_REQ;
            pdm_reg <= `RST_PDN_MODE;
            tmk_reg <= `RST_THERM_MASK;
        end else if (is_cold) begin
            gen_reg <= `RST_GLOBAL_EN;
            slp_reg <= `RST_SLEEP_REQ;
            pdm_reg <= `RST_PDN_MODE;
            tmk_reg <= `RST_THERM_MASK;
        end else begin
            gen_reg <= wr_gen ? reg_wdata : gen_reg;
            slp_reg <= wr_slp ? reg_wdata : slp_reg;
            pdm_reg <= wr_pdm ? reg_wdata : pdm_reg;
            tmk_reg <= wr_tmk ? reg_wdata : tmk_reg;
        end
    end

    wire [7:0] rd_mux =
        (reg_addr == `OFF_GLOBAL_EN)  ? gen_reg :
        (reg_addr == `OFF_SLEEP_REQ)  ? slp_reg :
        (reg_addr == `OFF_PDN_MODE)   ? pdm_reg :
        (reg_addr == `OFF_THERM_MASK) ? tmk_reg : 8'h00;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && !bus_reset) begin
            reg_rdata <= rd_mux;
        end
    end

    assign thermal_shutdown_flag = over_temp;
    assign state = state_reg;

    // ************************************************************
    // per-output sequencing
    // ************************************************************
    wire run_state  = is_active || is_sleep;
    // outputs drop on the edge that leaves the run states
    wire run_next   = (state_next == ST_ACTIVE) || (state_next == ST_SLEEP);
    wire kill_all   = !run_next;
    wire wake_on    = is_sleep && (state_next == ST_ACTIVE);
    wire seq_launch = (state_next == ST_ACTIVE) && !is_active && !is_sleep;
    wire [N_OUT+1:0] trig_src = {external_good_input, supply_in_window,
                                 ramp_done};

    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi++) begin : g_out
            logic [DLY_W-1:0] dly_reg;
            logic [SS_W-1:0]  ss_reg;
            wire [1:0] smode = sleep_mode[gi*2 +: 2];
            wire slp_on = (smode != 2'(SLP_OFF));
            wire [3:0] tsel = TRIG_SEL[gi*4 +: 4];
            always_ff @(posedge mclk or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    dly_reg <= '0;
                    ss_reg  <= '0;
                end else if (is_cold) begin
                    dly_reg <= DLY_DEFAULT[gi*DLY_W +: DLY_W];
                    ss_reg  <= SS_DEFAULT[gi*SS_W +: SS_W];
                end else begin
                    if (dly_we[gi]) dly_reg <= dly_wdata[gi*DLY_W +: DLY_W];
                    if (ss_we[gi])  ss_reg  <= ss_wdata[gi*SS_W +: SS_W];
                end
            end
            output_sequencer #(
                .DLY_W (DLY_W),
                .SS_W  (SS_W)
            ) u_seq (
                .mclk                (mclk),
                .rst_sync_b          (rst_sync_b),
                .seq_start           (seq_launch),
                .direct_on           (wake_on),
                .kill                (kill_all || (is_active
                                      && state_next == ST_SLEEP && !slp_on)),
                .trigger             (trig_src[tsel]),
                .turn_on_delay_field (dly_reg),
                .soft_start_field    (ss_reg),
                .out_enable          (seq_en[gi]),
                .ramp_done           (ramp_done[gi])
            );
            if (gi < N_BUCK) begin : g_buck
                assign buck_use_alternate[gi] = is_sleep
                    ? (smode == 2'(SLP_ALTERNATE)) : dvs_select;
            end
        end
    endgenerate

    assign out_enable = seq_en;
    assign main_reset_out_b    = run_state;
    assign aux_reset_out_one_b = run_state;
    assign aux_reset_out_two_b = run_state;

    // ************************************************************
    // checks
    // ************************************************************
    a_cold_outputs_off: assert property (
        is_cold |-> (out_enable == '0) && !main_reset_out_b)
        else $error("outputs on in cold reset");
    a_lockout_to_cold: assert property (
        supply_below_lockout |=> is_cold)
        else $error("lockout did not force cold");
    a_cold_to_active: assert property (
        is_cold && supply_in_window && !supply_below_lockout |=> is_active)
        else $error("valid supply did not activate");
    a_thermal_entry: assert property (
        is_active && therm_trip && !supply_below_lockout
        |=> state_reg == ST_THERMAL ##1 out_enable == '0)
        else $error("thermal entry missed");
    a_thermal_masked: assert property (
        !tmk_reg[`BIT_THERM_UNMASK] |=> state_reg != ST_THERMAL)
        else $error("masked thermal entered");
    a_fault_priority: assert property (
        is_active && sleep_write && (ov_trip || uv_trip) && !therm_trip
        && !supply_below_lockout |=> state_reg == ST_VFAULT)
        else $error("sleep beat fault");
    a_sleep_entry: assert property (
        is_active && sleep_write && !therm_trip && !ov_trip && !uv_trip
        && !supply_below_lockout |=> is_sleep)
        else $error("bus sleep request lost");
    a_bus_held: assert property (
        (is_cold || state_reg == ST_VFAULT) |-> bus_reset)
        else $error("bus live in fault or cold");
    a_fault_retry: assert property (
        state_reg == ST_VFAULT && retry_cnt_reg == 32'(RETRY_CYCLES - 1)
        && !supply_below_lockout |=> is_active)
        else $error("retry not taken");
endmodule : pmic_state_ctrl
`default_nettype wire

// file: tb/host_port_model.sv
// host side model that drives the register strobes
`default_nettype none
module host_port_model (
    input  wire logic bus_reset,
    input  wire logic cmd_wr,
    input  wire logic cmd_rd,
    output logic      reg_wr,
    output logic      reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // the host never talks while the port is held in reset
    assign reg_wr = cmd_wr & ~bus_reset;
    assign reg_rd = cmd_rd & ~bus_reset;
endmodule : host_port_model
`default_nettype wire

// file: tb/pmic_state_ctrl_bench.sv
// self-checking bench for the power state and sequencing controller
`default_nettype none
module pmic_state_ctrl_bench
    import pmic_seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        win = 1'b0, lock = 1'b0, hot = 1'b0, pin = 1'b0, ext = 1'b0;
    logic        ov_un = 1'b0, uv_un = 1'b0, cwr = 1'b0, crd = 1'b0;
    logic        dynamic_voltage_scaling = 1'b0;
    logic [6:0]  ov = '0, uv = '0, oe;
    logic [13:0] slp = '0;
    logic [7:0]  addr = '0, wdata = '0, rdata, v;
    logic        rwr, rrd, brst, tflag, r0, r1, r2;
    logic [3:0]  balt;
    pmic_state_t state;
    int          failures = 0, num_checks = 0, i;

    always #10 mclk = ~mclk;

    pmic_state_ctrl #(.RETRY_CYCLES(20),
        .TRIG_SEL({4'h8, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'h7}),
        .DLY_DEFAULT({7{16'h0003}}), .SS_DEFAULT({7{16'h0002}})) u_dut (
        .mclk(mclk), .rst_b(rst_b), .supply_in_window(win),
        .supply_below_lockout(lock), .over_temp(hot),
        .out_over_voltage(ov), .out_under_voltage(uv),
        .overvoltage_unmask(ov_un), .undervoltage_unmask(uv_un),
        .power_enable_pin(pin), .external_good_input(ext),
        .dvs_select(dynamic_voltage_scaling), .sleep_mode(slp), .dly_wdata('0), .dly_we('0),
        .ss_wdata('0), .ss_we('0), .reg_wr(rwr), .reg_rd(rrd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .bus_reset(brst), .out_enable(oe), .buck_use_alternate(balt),
        .thermal_shutdown_flag(tflag), .state(state),
        .main_reset_out_b(r0), .aux_reset_out_one_b(r1),
        .aux_reset_out_two_b(r2));

    host_port_model u_host (.bus_reset(brst), .cmd_wr(cwr), .cmd_rd(crd),
        .reg_wr(rwr), .reg_rd(rrd));

    // ****************************************************
    // access and compare tasks
    // ****************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_st(input pmic_state_t got, input pmic_state_t exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: state %b exp %b", $time, got, exp);
        end
    endtask : chk_st
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wdata = d;
        cwr = 1'b1;
        @(negedge mclk);
        cwr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        addr = a;
        crd = 1'b1;
        @(negedge mclk);
        crd = 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask : rd
    task automatic rmw(input logic [7:0] a, input logic [7:0] s);
        logic [7:0] t;
        rd(a, t);
        wr(a, t | s);
    endtask : rmw
    task automatic wait_st(input pmic_state_t s, input int n);
        for (i = 0; i < n && state !== s; i++) @(negedge mclk);
        chk_st(state, s);
    endtask : wait_st
    task automatic wait_oe(input logic [6:0] e, input int n);
        for (i = 0; i < n && oe !== e; i++) @(negedge mclk);
        chk({1'b0, oe}, {1'b0, e});
    endtask : wait_oe
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial begin
        #100us;
        failures++;
        results();
    end

    // ****************************************************
    // test sequence
    // ****************************************************
    initial begin
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        chk_st(state, ST_COLD);
        chk({1'b0, oe}, 8'h00);
        chk({5'h0, r0, r1, r2}, 8'h00);
        win = 1'b1;
        wait_st(ST_ACTIVE, 10);
        chk({1'b0, oe}, 8'h00);
        wait_oe(7'h3f, 100);
        repeat (20) @(negedge mclk);
        chk({1'b0, oe}, 8'h3f);
        ext = 1'b1;
        wait_oe(7'h7f, 20);
        rd(8'h0a, v);
        chk(v, 8'h10);
        rd(8'h05, v);
        chk(v, 8'h00);
        wr(8'h0a, 8'h00);
        hot = 1'b1;
        repeat (5) @(negedge mclk);
        chk_st(state, ST_ACTIVE);
        chk({7'h0, tflag}, 8'h01);
        wr(8'h08, 8'h02);
        rmw(8'h0a, 8'h10);
        wait_st(ST_THERMAL, 5);
        chk({1'b0, oe}, 8'h00);
        chk({5'h0, r0, r1, r2}, 8'h00);
        hot = 1'b0;
        wait_st(ST_ACTIVE, 20);
        rd(8'h08, v);
        chk(v, 8'h00);
        wait_oe(7'h7f, 100);
        slp = {10'h2aa, 2'h1, 2'h0};
        rmw(8'h08, 8'h02);
        rmw(8'h00, 8'h01);
        wr(8'h01, 8'h02);
        chk_st(state, ST_SLEEP);
        chk({7'h0, brst}, 8'h01);
        @(negedge mclk);
        chk({1'b0, oe}, 8'h03);
        chk({4'h0, balt}, 8'h02);
        pin = 1'b1;
        wait_st(ST_ACTIVE, 5);
        repeat (2) @(negedge mclk);
        chk({1'b0, oe}, 8'h7f);
        chk({4'h0, balt}, 8'h00);
        dynamic_voltage_scaling = 1'b1;
        @(negedge mclk);
        chk({4'h0, balt}, 8'h0f);
        dynamic_voltage_scaling = 1'b0;
        ov_un = 1'b1;
        ov = 7'h01;
        wait_st(ST_VFAULT, 5);
        chk({1'b0, oe}, 8'h00);
        chk({5'h0, r0, r1, r2}, 8'h00);
        for (i = 0; i < 200 && state === ST_VFAULT; i++) @(negedge mclk);
        chk({7'h0, i >= 18 && i <= 22}, 8'h01);
        wait_st(ST_VFAULT, 60);
        ov = 7'h00;
        wait_st(ST_ACTIVE, 30);
        repeat (50) @(negedge mclk);
        chk_st(state, ST_ACTIVE);
        uv_un = 1'b1;
        uv = 7'h40;
        wait_st(ST_VFAULT, 5);
        uv = 7'h00;
        wait_st(ST_ACTIVE, 30);
        lock = 1'b1;
        wait_st(ST_COLD, 5);
        chk({1'b0, oe}, 8'h00);
        results();
    end
endmodule : pmic_state_ctrl_bench
`default_nettype wire
